// [core/crd_datapath.sv]
// CPU register datapath: accumulator, carry, temp, pair, pointer, step clock
// Contract
// RULE_01 - Arithmetic unit works on 4-bit operands: add, compare, and, or, bit ops.
// RULE_02 - Accumulator is 4 bits, operand and result for arithmetic, transfer, ports.
// RULE_03 - Add-with-carry sets the carry flag when the sum carries out.
// RULE_04 - Add-immediate and add-memory leave the carry flag untouched.
// RULE_05 - Rotate-right copies accumulator bit 0 into the carry flag.
// RULE_06 - Carry-set forces carry to 1, carry-clear forces it to 0.
// RULE_07 - Temporary register holds 4 bits and pairs with accumulator for 8 bits.
// RULE_08 - Pair register is 8 bits: upper nibble temporary, lower accumulator.
// RULE_09 - Software must initialise the pair register after reset.
// RULE_10 - Pointer is 3 bits; with accumulator it forms a 7-bit page address.
// RULE_11 - Lookup with upper flag set loads word bits 9:8 into pointer, top bit 0.
// RULE_12 - Lookup with upper flag clear leaves the pointer alone.
// RULE_13 - Upper flag resets to 0; set op makes 1, clear op makes 0.
// RULE_14 - Software must initialise the pointer register after reset.
// RULE_15 - Step clock is the system clock divided by three.
// RULE_16 - One step clock cycle is one machine cycle.
// RULE_17 - Program words are ten bits; lookup returns the low eight bits.
// RULE_18 - Lookup reads bits 7 to 0 of any program address as data.
// RULE_19 - Rotate-right shifts accumulator right, old carry enters bit 3.
`timescale 1ns/100ps
module crd_datapath
  import crd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic op_valid_i,
  input wire crd_op_e op_i,
  input wire logic [NIB_W-1:0] imm_i,
  input wire logic [NIB_W-1:0] mem_rd_i,
  input wire logic [BIT_SEL_W-1:0] bit_sel_i,
  input wire logic [ROM_WORD_W-1:0] rom_word_i,
  input wire logic [NIB_W-1:0] port_pin_i,
  output logic step_o,
  output logic [NIB_W-1:0] acc_o,
  output logic carry_flag_o,
  output logic [NIB_W-1:0] tmp_o,
  output logic [PAIR_W-1:0] pair_o,
  output logic [PTR_W-1:0] ptr_o,
  output logic upper_bits_load_flag_o,
  output logic [ROM_ADDR_W-1:0] rom_addr_o,
  output logic skip_o,
  output logic mem_we_o,
  output logic [NIB_W-1:0] mem_wr_o,
  output logic [NIB_W-1:0] port_out_o
);

  // ---------------------------------------------------------------
  // Step clock divider
  // ---------------------------------------------------------------
  logic [1:0] div_q, div_d;
  logic step_en;
  logic step_q, step_d;

  always_comb begin
    step_en = (div_q == STEP_DIV_LAST); // [RULE_15]
    div_d = step_en ? STEP_CNT_RST : div_q + 2'h1;
    step_d = step_en; // [RULE_16]
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= STEP_CNT_RST;
      step_q <= 1'b0;
    end else begin
      div_q <= div_d;
      step_q <= step_d;
    end
  end

  // ---------------------------------------------------------------
  // Port input synchroniser
  // ---------------------------------------------------------------
  logic [NIB_W-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_val_q, pin_val_d;

  always_comb begin
    pin_val_d = pin_val_q;
    if (pin_s2_q == pin_s3_q) begin
      pin_val_d = pin_s3_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= NIB_RST;
      pin_s2_q <= NIB_RST;
      pin_s3_q <= NIB_RST;
      pin_val_q <= NIB_RST;
    end else begin
      pin_s1_q <= port_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_val_q <= pin_val_d;
    end
  end

  // ---------------------------------------------------------------
  // Arithmetic unit
  // ---------------------------------------------------------------
  logic [NIB_W-1:0] acc_q, acc_d, tmp_q, tmp_d, wr_q, wr_d, pout_q, pout_d;
  logic [PAIR_W-1:0] pair_q, pair_d;
  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic carry_q, carry_d, upper_q, upper_d, skip_q, skip_d, we_q, we_d;
  logic [ROM_ADDR_W-1:0] addr_q, addr_d;

  crd_alu_if alu_bus ();

  crd_alu u_alu (
    .alu(alu_bus)
  );

  logic exec;

  always_comb begin
    exec = step_en && op_valid_i;
    alu_bus.a = acc_q;
    alu_bus.b = mem_rd_i;
    alu_bus.cin = 1'b0;
    alu_bus.sel = bit_sel_i;
    case (op_i)
      OP_ADD_CARRY: begin
        alu_bus.fn = ALU_ADD;
        alu_bus.cin = carry_q;
      end
      OP_ADD_IMM: begin
        alu_bus.fn = ALU_ADD;
        alu_bus.b = imm_i;
      end
      OP_ADD_MEM: alu_bus.fn = ALU_ADD;
      OP_AND_MEM: alu_bus.fn = ALU_AND;
      OP_OR_MEM: alu_bus.fn = ALU_OR;
      OP_BIT_SET: alu_bus.fn = ALU_BSET;
      OP_BIT_CLEAR: alu_bus.fn = ALU_BCLR;
      default: alu_bus.fn = ALU_PASS;
    endcase
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    tmp_d = tmp_q;
    pair_d = pair_q;
    ptr_d = ptr_q;
    carry_d = carry_q;
    upper_d = upper_q;
    skip_d = skip_q;
    we_d = 1'b0;
    wr_d = wr_q;
    pout_d = pout_q;
    if (exec) begin
      skip_d = 1'b0;
      case (op_i)
        OP_ADD_CARRY: begin
          acc_d = alu_bus.res; // [RULE_02]
          carry_d = alu_bus.cout; // [RULE_03]
        end
        OP_ADD_IMM, OP_ADD_MEM: acc_d = alu_bus.res; // [RULE_04]
        OP_AND_MEM, OP_OR_MEM: acc_d = alu_bus.res; // [RULE_01]
        OP_ROTATE_RIGHT: begin
          carry_d = acc_q[0]; // [RULE_05]
          acc_d = {carry_q, acc_q[NIB_W-1:1]}; // [RULE_19]
        end
        OP_CARRY_SET: carry_d = 1'b1; // [RULE_06]
        OP_CARRY_CLEAR: carry_d = 1'b0; // [RULE_06]
        OP_CMP_MEM: skip_d = alu_bus.eq; // [RULE_01]
        OP_BIT_SET, OP_BIT_CLEAR: begin
          we_d = 1'b1;
          wr_d = alu_bus.res; // [RULE_01]
        end
        OP_BIT_TEST: skip_d = !alu_bus.bit_val;
        OP_LOAD_IMM: acc_d = imm_i;
        OP_ACC_TO_TMP: tmp_d = acc_q; // [RULE_07]
        OP_TMP_TO_ACC: acc_d = tmp_q;
        OP_XCH_TMP: begin
          acc_d = tmp_q;
          tmp_d = acc_q;
        end
        OP_PAIR_LOAD: pair_d = {tmp_q, acc_q}; // [RULE_08]
        OP_PAIR_STORE: begin
          tmp_d = pair_q[PAIR_W-1:NIB_W]; // [RULE_08]
          acc_d = pair_q[NIB_W-1:0];
        end
        OP_PTR_LOAD: ptr_d = imm_i[PTR_W-1:0];
        OP_TABLE_LOOKUP: begin
          acc_d = rom_word_i[ROM_LO_LSB +: NIB_W]; // [RULE_17] [RULE_18]
          tmp_d = rom_word_i[ROM_HI_LSB +: NIB_W]; // [RULE_07]
          if (upper_q) begin
            ptr_d = {1'b0, rom_word_i[ROM_UP_LSB +: PTR_W-1]}; // [RULE_11]
          end
        end
        OP_UPPER_SET: upper_d = 1'b1; // [RULE_13]
        OP_UPPER_CLEAR: upper_d = 1'b0; // [RULE_13]
        OP_PORT_IN: acc_d = pin_val_q;
        OP_PORT_OUT: pout_d = acc_q;
        default: skip_d = 1'b0;
      endcase
    end
    addr_d = {ptr_d, acc_d}; // [RULE_10]
  end

  // Pair and pointer reset to zero, but software must still load them
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= NIB_RST;
      tmp_q <= NIB_RST;
      pair_q <= PAIR_RST; // [RULE_09]
      ptr_q <= PTR_RST; // [RULE_14]
      carry_q <= CARRY_RST;
      upper_q <= UPPER_RST; // [RULE_13]
      skip_q <= 1'b0;
      we_q <= 1'b0;
      wr_q <= NIB_RST;
      pout_q <= NIB_RST;
      addr_q <= {PTR_RST, NIB_RST};
    end else begin
      acc_q <= acc_d;
      tmp_q <= tmp_d;
      pair_q <= pair_d;
      ptr_q <= ptr_d;
      carry_q <= carry_d;
      upper_q <= upper_d;
      skip_q <= skip_d;
      we_q <= we_d;
      wr_q <= wr_d;
      pout_q <= pout_d;
      addr_q <= addr_d;
    end
  end

  always_comb begin
    step_o = step_q;
    acc_o = acc_q;
    carry_flag_o = carry_q;
    tmp_o = tmp_q;
    pair_o = pair_q;
    ptr_o = ptr_q;
    upper_bits_load_flag_o = upper_q;
    rom_addr_o = addr_q;
    skip_o = skip_q;
    mem_we_o = we_q;
    mem_wr_o = wr_q;
    port_out_o = pout_q;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [NIB_W:0] adc_ref;
  assign adc_ref = {1'b0, acc_q} + {1'b0, mem_rd_i} + {{NIB_W{1'b0}}, carry_q};

  sequence seq_step_gap;
    !step_o ##1 !step_o ##1 step_o;
  endsequence

  sequence seq_do(crd_op_e o);
    exec && op_i == o;
  endsequence

  AST_STEP_DIV3: assert property (step_o |=> seq_step_gap) // [RULE_15]
    else $error("step pulse not every third clock");
  AST_ADC_CARRY: assert property (seq_do(OP_ADD_CARRY) // [RULE_03]
    |=> {carry_flag_o, acc_o} == $past(adc_ref))
    else $error("add with carry result or carry wrong");
  AST_ADD_KEEPS_CARRY: assert property ((seq_do(OP_ADD_IMM) or seq_do(OP_ADD_MEM)) // [RULE_04]
    |=> $stable(carry_flag_o))
    else $error("plain add changed carry");
  AST_ROTATE: assert property (seq_do(OP_ROTATE_RIGHT) |=> carry_flag_o == $past(acc_o[0]) // [RULE_05]
    && acc_o == {$past(carry_flag_o), $past(acc_o[3:1])})
    else $error("rotate right wrong");
  AST_CARRY_FORCE: assert property ((seq_do(OP_CARRY_SET) |=> carry_flag_o) // [RULE_06]
    and (seq_do(OP_CARRY_CLEAR) |=> !carry_flag_o))
    else $error("carry force wrong");
  AST_PAIR_MAP: assert property (seq_do(OP_PAIR_STORE) |=> {tmp_o, acc_o} == $past(pair_o)) // [RULE_08]
    else $error("pair split wrong");
  AST_ROM_ADDR: assert property (##1 rom_addr_o == {ptr_o, acc_o}) // [RULE_10]
    else $error("page address not pointer and accumulator");
  AST_LOOKUP_UPPER: assert property (seq_do(OP_TABLE_LOOKUP) ##0 upper_q // [RULE_11]
    |=> ptr_o == {1'b0, $past(rom_word_i[9:8])})
    else $error("lookup did not load pointer");
  AST_LOOKUP_KEEP: assert property (seq_do(OP_TABLE_LOOKUP) ##0 !upper_q // [RULE_12]
    |=> $stable(ptr_o))
    else $error("lookup changed pointer");
  AST_UPPER_FLAG: assert property ((seq_do(OP_UPPER_SET) |=> upper_bits_load_flag_o) // [RULE_13]
    and (seq_do(OP_UPPER_CLEAR) |=> !upper_bits_load_flag_o))
    else $error("upper flag op wrong");

endmodule

// [core/crd_pkg.sv]
// Shared constants and types for the CPU register datapath
package crd_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned NIB_W = 4;
  localparam int unsigned PAIR_W = 8;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned ROM_ADDR_W = 7;
  localparam int unsigned ROM_WORD_W = 10;
  localparam int unsigned BIT_SEL_W = 2;

  // ---------------------------------------------------------------
  // Step clock divider
  // ---------------------------------------------------------------
  localparam logic [1:0] STEP_DIV_LAST = 2'h2;
  localparam logic [1:0] STEP_CNT_RST = 2'h0;

  // ---------------------------------------------------------------
  // Program word fields
  // ---------------------------------------------------------------
  localparam int unsigned ROM_LO_LSB = 0;
  localparam int unsigned ROM_HI_LSB = 4;
  localparam int unsigned ROM_UP_LSB = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [7:0] PAIR_RST = 8'h00;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic UPPER_RST = 1'b0;
  localparam logic CARRY_RST = 1'b0;

  // ---------------------------------------------------------------
  // Operations
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP,
    OP_ADD_CARRY,
    OP_ADD_IMM,
    OP_ADD_MEM,
    OP_ROTATE_RIGHT,
    OP_CARRY_SET,
    OP_CARRY_CLEAR,
    OP_AND_MEM,
    OP_OR_MEM,
    OP_CMP_MEM,
    OP_BIT_SET,
    OP_BIT_CLEAR,
    OP_BIT_TEST,
    OP_LOAD_IMM,
    OP_ACC_TO_TMP,
    OP_TMP_TO_ACC,
    OP_XCH_TMP,
    OP_PAIR_LOAD,
    OP_PAIR_STORE,
    OP_PTR_LOAD,
    OP_TABLE_LOOKUP,
    OP_UPPER_SET,
    OP_UPPER_CLEAR,
    OP_PORT_IN,
    OP_PORT_OUT
  } crd_op_e;

  typedef enum logic [2:0] {
    ALU_ADD,
    ALU_AND,
    ALU_OR,
    ALU_BSET,
    ALU_BCLR,
    ALU_PASS
  } crd_alu_fn_e;

endpackage

// [core/crd_alu_if.sv]
// Connection between the datapath control and the arithmetic unit
`timescale 1ns/100ps
interface crd_alu_if;
  import crd_pkg::*;
  logic [NIB_W-1:0] a;
  logic [NIB_W-1:0] b;
  logic cin;
  crd_alu_fn_e fn;
  logic [BIT_SEL_W-1:0] sel;
  logic [NIB_W-1:0] res;
  logic cout;
  logic eq;
  logic bit_val;
  modport user (output a, b, cin, fn, sel, input res, cout, eq, bit_val);
  modport unit (input a, b, cin, fn, sel, output res, cout, eq, bit_val);
endinterface

// [core/crd_alu.sv]
// Four-bit arithmetic unit: add, compare, and, or, bit manipulation
`timescale 1ns/100ps
module crd_alu
  import crd_pkg::*;
(
  crd_alu_if.unit alu
);

  logic [NIB_W:0] sum;

  always_comb begin
    sum = {1'b0, alu.a} + {1'b0, alu.b} + {{NIB_W{1'b0}}, alu.cin};
    alu.cout = 1'b0;
    alu.eq = (alu.a == alu.b);
    alu.bit_val = alu.b[alu.sel];
    case (alu.fn)
      ALU_ADD: begin
        alu.res = sum[NIB_W-1:0];
        alu.cout = sum[NIB_W];
      end
      ALU_AND: alu.res = alu.a & alu.b;
      ALU_OR: alu.res = alu.a | alu.b;
      ALU_BSET: begin
        alu.res = alu.b;
        alu.res[alu.sel] = 1'b1;
      end
      ALU_BCLR: begin
        alu.res = alu.b;
        alu.res[alu.sel] = 1'b0;
      end
      ALU_PASS: alu.res = alu.b;
      default: alu.res = alu.b;
    endcase
  end

endmodule

// [tb/tb_crd_datapath.sv]
// Self-checking testbench for the CPU register datapath
`timescale 1ns/100ps
module tb_crd_datapath;
  import crd_pkg::*;
  // ---------------------------------------------------------------
  // Signals and clock
  // ---------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  crd_op_e op_i = OP_NOP;
  logic [3:0] imm_i = 4'h0;
  logic [3:0] mem_rd_i = 4'h0;
  logic [1:0] bit_sel_i = 2'h0;
  logic [9:0] rom_word_i = 10'h000;
  logic [3:0] port_pin_i = 4'h0;
  logic step_o, carry_flag_o, upper_bits_load_flag_o, skip_o, mem_we_o;
  logic [3:0] acc_o, tmp_o, mem_wr_o, port_out_o;
  logic [7:0] pair_o;
  logic [2:0] ptr_o;
  logic [6:0] rom_addr_o;
  int err_count = 0;
  int total_checks = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  crd_datapath i_dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .op_valid_i(op_valid_i),
    .op_i(op_i),
    .imm_i(imm_i),
    .mem_rd_i(mem_rd_i),
    .bit_sel_i(bit_sel_i),
    .rom_word_i(rom_word_i),
    .port_pin_i(port_pin_i),
    .step_o(step_o),
    .acc_o(acc_o),
    .carry_flag_o(carry_flag_o),
    .tmp_o(tmp_o),
    .pair_o(pair_o),
    .ptr_o(ptr_o),
    .upper_bits_load_flag_o(upper_bits_load_flag_o),
    .rom_addr_o(rom_addr_o),
    .skip_o(skip_o),
    .mem_we_o(mem_we_o),
    .mem_wr_o(mem_wr_o),
    .port_out_o(port_out_o)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Presents one op and holds it until its machine cycle has executed it
  task do_op(input crd_op_e op, input logic [3:0] v = 4'h0, input logic [3:0] m = 4'h0,
             input logic [1:0] b = 2'h0, input logic [9:0] w = 10'h000);
    int n;
    @(negedge ref_clk_i);
    op_i = op;
    imm_i = v;
    mem_rd_i = m;
    bit_sel_i = b;
    rom_word_i = w;
    op_valid_i = 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (step_o !== 1'b1 && n < 4);
    chk("op taken", {7'h00, step_o}, 8'h01);
    op_valid_i = 1'b0;
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    chk("acc", {4'h0, acc_o}, 8'h00);
    chk("carry", {7'h00, carry_flag_o}, 8'h00);
    chk("upper", {7'h00, upper_bits_load_flag_o}, 8'h00);
  endtask

  task t_step;
    logic [7:0] cnt;
    cnt = 8'h00;
    repeat (9) begin
      @(negedge ref_clk_i);
      if (step_o === 1'b1) cnt = cnt + 8'h01;
    end
    chk("step count", cnt, 8'h03);
  endtask

  task t_carry;
    do_op(OP_CARRY_SET);
    chk("carry", {7'h00, carry_flag_o}, 8'h01);
    do_op(OP_CARRY_CLEAR);
    chk("carry", {7'h00, carry_flag_o}, 8'h00);
  endtask

  task t_add;
    do_op(OP_LOAD_IMM, 4'h8);
    do_op(OP_CARRY_SET);
    do_op(OP_ADD_CARRY, 4'h0, 4'h9);
    chk("acc", {4'h0, acc_o}, 8'h02);
    chk("carry", {7'h00, carry_flag_o}, 8'h01);
    do_op(OP_LOAD_IMM, 4'h3);
    do_op(OP_ADD_CARRY, 4'h0, 4'h4);
    chk("acc", {4'h0, acc_o}, 8'h08);
    chk("carry", {7'h00, carry_flag_o}, 8'h00);
  endtask

  task t_keep;
    do_op(OP_CARRY_SET);
    do_op(OP_LOAD_IMM, 4'hf);
    do_op(OP_ADD_IMM, 4'h1);
    chk("acc", {4'h0, acc_o}, 8'h00);
    chk("carry", {7'h00, carry_flag_o}, 8'h01);
    do_op(OP_CARRY_CLEAR);
    do_op(OP_LOAD_IMM, 4'hf);
    do_op(OP_ADD_MEM, 4'h0, 4'h2);
    chk("acc", {4'h0, acc_o}, 8'h01);
    chk("carry", {7'h00, carry_flag_o}, 8'h00);
  endtask

  task t_rot;
    do_op(OP_LOAD_IMM, 4'h5);
    do_op(OP_ROTATE_RIGHT);
    chk("acc", {4'h0, acc_o}, 8'h02);
    chk("carry", {7'h00, carry_flag_o}, 8'h01);
    do_op(OP_ROTATE_RIGHT);
    chk("acc", {4'h0, acc_o}, 8'h09);
    chk("carry", {7'h00, carry_flag_o}, 8'h00);
  endtask

  task t_logic;
    do_op(OP_LOAD_IMM, 4'hc);
    do_op(OP_AND_MEM, 4'h0, 4'ha);
    chk("acc", {4'h0, acc_o}, 8'h08);
    do_op(OP_OR_MEM, 4'h0, 4'h3);
    chk("acc", {4'h0, acc_o}, 8'h0b);
    do_op(OP_CMP_MEM, 4'h0, 4'hb);
    chk("skip", {7'h00, skip_o}, 8'h01);
    do_op(OP_NOP);
    chk("skip", {7'h00, skip_o}, 8'h00);
    do_op(OP_BIT_SET, 4'h0, 4'h0, 2'h2);
    chk("mem write", {7'h00, mem_we_o}, 8'h01);
    chk("mem data", {4'h0, mem_wr_o}, 8'h04);
    @(negedge ref_clk_i);
    chk("mem write", {7'h00, mem_we_o}, 8'h00);
    do_op(OP_BIT_CLEAR, 4'h0, 4'hf, 2'h0);
    chk("mem data", {4'h0, mem_wr_o}, 8'h0e);
    do_op(OP_BIT_TEST, 4'h0, 4'he, 2'h0);
    chk("skip", {7'h00, skip_o}, 8'h01);
    do_op(OP_BIT_TEST, 4'h0, 4'he, 2'h3);
    chk("skip", {7'h00, skip_o}, 8'h00);
  endtask

  task t_pair;
    do_op(OP_LOAD_IMM, 4'h6);
    do_op(OP_ACC_TO_TMP);
    chk("tmp", {4'h0, tmp_o}, 8'h06);
    do_op(OP_LOAD_IMM, 4'ha);
    do_op(OP_PAIR_LOAD);
    chk("pair", pair_o, 8'h6a);
    do_op(OP_LOAD_IMM, 4'h1);
    do_op(OP_ACC_TO_TMP);
    do_op(OP_PAIR_STORE);
    chk("pair hi", {4'h0, tmp_o}, 8'h06);
    chk("pair lo", {4'h0, acc_o}, 8'h0a);
    do_op(OP_XCH_TMP);
    chk("xch", {tmp_o, acc_o}, 8'ha6);
    do_op(OP_TMP_TO_ACC);
    chk("acc", {4'h0, acc_o}, 8'h0a);
  endtask

  task t_table;
    do_op(OP_PTR_LOAD, 4'h5);
    do_op(OP_LOAD_IMM, 4'h3);
    chk("rom addr", {1'b0, rom_addr_o}, 8'h53);
    do_op(OP_UPPER_CLEAR);
    do_op(OP_TABLE_LOOKUP, 4'h0, 4'h0, 2'h0, 10'h3c5);
    chk("lookup", {tmp_o, acc_o}, 8'hc5);
    chk("ptr", {5'h00, ptr_o}, 8'h05);
    do_op(OP_UPPER_SET);
    chk("upper", {7'h00, upper_bits_load_flag_o}, 8'h01);
    do_op(OP_PTR_LOAD, 4'h7);
    do_op(OP_TABLE_LOOKUP, 4'h0, 4'h0, 2'h0, 10'h2a7);
    chk("lookup", {tmp_o, acc_o}, 8'ha7);
    chk("ptr", {5'h00, ptr_o}, 8'h02);
    chk("rom addr", {1'b0, rom_addr_o}, 8'h27);
    do_op(OP_UPPER_CLEAR);
    chk("upper", {7'h00, upper_bits_load_flag_o}, 8'h00);
  endtask

  task t_port;
    @(negedge ref_clk_i);
    port_pin_i = 4'h9;
    repeat (6) @(negedge ref_clk_i);
    do_op(OP_PORT_IN);
    chk("acc", {4'h0, acc_o}, 8'h09);
    do_op(OP_PORT_OUT);
    chk("port out", {4'h0, port_out_o}, 8'h09);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_step();
    t_carry();
    t_add();
    t_keep();
    t_rot();
    t_logic();
    t_pair();
    t_table();
    t_port();
    complete_run();
  end

  initial begin
    #(5000 * 100);
    err_count++;
    complete_run();
  end
endmodule
